// ### include/i2c_seq_pkg.sv
// Shared constants for the sequencer I2C data-transfer command block.
package i2c_seq_pkg;
	// Opcodes of the three data-transfer commands.
	localparam logic [7:0] OP_WRITE_DATA = 8'hE3;
	localparam logic [7:0] OP_READ_ACK = 8'hD4;
	localparam logic [7:0] OP_READ_NACK = 8'hD3;
	// Packet SRAM geometry: 512 bytes.
	localparam int ADDR_W = 9;
	localparam int SRAM_DEPTH = 512;
	// Byte count width, a zero length byte means this full count.
	localparam int CNT_W = 9;
	localparam logic [8:0] FULL_COUNT = 9'h100;
	// Reserved read-array filler value.
	localparam logic [7:0] READ_FILL = 8'hFF;
	// Clock rate and I2C bit timing, 100 kHz standard mode.
	localparam int CLK_HZ = 125000000;
	localparam int I2C_HZ = 100000;
	// Four quarter phases make one SCL period; integer division rounds down, giving the shorter quarter.
	localparam int QUARTER_CYCLES = CLK_HZ / (I2C_HZ * 4);
	localparam int QTR_W = 10;
	localparam logic [9:0] QUARTER_LAST = 10'(QUARTER_CYCLES - 1);
	// Bits per byte on the wire, plus the acknowledge slot.
	localparam logic [3:0] LAST_BIT = 4'h8;
endpackage

// ### rtl/seq_sram.sv
// Packet SRAM holding sequencer command packets, with registered read data.
`timescale 1ns/1ps
module seq_sram
	import i2c_seq_pkg::*;
(
	// Clock.
	input wire logic clk,
	// Write port.
	input wire logic we,
	input wire logic [ADDR_W-1:0] waddr,
	input wire logic [7:0] wdata,
	// Read port.
	input wire logic [ADDR_W-1:0] raddr,
	output logic [7:0] rdata
);
	// Storage array; contents survive until overwritten.
	logic [7:0] mem [SRAM_DEPTH];

	// One write and one registered read per cycle.
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

// ### rtl/i2c_data_cmds.sv
// Sequencer executor for the I2C write, read-ACK and read-NACK data commands.
// Contract
// RL1 - E3h: length byte, then send bytes.
// RL2 - Write length zero means 256 bytes.
// RL3 - Author places write after Start, then Stop.
// RL4 - D4h: read length bytes, ACK each.
// RL5 - Read length zero means 256 bytes.
// RL6 - Packet reserves FFh byte per read.
// RL7 - Each received byte overwrites SRAM immediately.
// RL8 - D3h: ACK all but last, NACK last.
// RL9 - NACK-read length zero means 256 bytes.
// RL10 - Reads follow Start, address, repeated Start.
// RL11 - Host link bytes ignored while executing.
// RL12 - Host keeps strong pullup power active.
// RL13 - Write samples ACK, MSB first, counts.
`timescale 1ns/1ps
module i2c_data_cmds
	import i2c_seq_pkg::*;
(
	// Clock and reset.
	input wire logic CLK_IN,
	input wire logic RESET_IN,
	// Sequencer control: start pulse, packet address, completion.
	input wire logic RUN_IN,
	input wire logic [ADDR_W-1:0] START_ADDR_IN,
	output logic BUSY_OUT,
	output logic DONE_OUT,
	output logic [ADDR_W-1:0] NEXT_ADDR_OUT,
	output logic NACK_SEEN_OUT,
	output logic BAD_OP_OUT,
	// Packet loading from the host link, same clock domain.
	input wire logic HOST_WE_IN,
	input wire logic [ADDR_W-1:0] HOST_ADDR_IN,
	input wire logic [7:0] HOST_DATA_IN,
	output logic HOST_IGNORED_OUT,
	// I2C pins: input, output, and enable (low while driving low).
	input wire logic SCL_IN,
	output logic SCL_OUT,
	output logic SCL_OE_N_OUT,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE_N_OUT
);
	// Command sequencing states.
	typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_LEN, ST_FETCH, ST_BYTE, ST_STORE, ST_END} state_t;

	// Zero length byte expands to the full count.
	function automatic logic [CNT_W-1:0] len_of(input logic [7:0] b);
		len_of = (b == 8'h00) ? FULL_COUNT : {1'b0, b};
	endfunction

	state_t state_reg, state_next;
	logic [ADDR_W-1:0] addr_reg; // Current packet pointer.
	logic [7:0] op_reg; // Decoded opcode.
	logic [CNT_W-1:0] cnt_reg; // Bytes remaining.
	logic [7:0] shift_reg; // Byte being sent or received.
	logic [3:0] bit_reg; // Bit slot 0..7, 8 is acknowledge.
	logic [1:0] phase_reg; // Quarter phase within an SCL period.
	logic [QTR_W-1:0] qtr_reg; // Quarter-period divider.
	logic scl_lo_reg, sda_lo_reg; // Pin pull-down drive.
	logic nack_reg, bad_reg, done_reg, ign_reg;
	logic [ADDR_W-1:0] next_addr_reg;
	logic sda_s1_reg, sda_s2_reg; // SDA synchroniser.
	logic scl_s1_reg, scl_s2_reg; // SCL synchroniser, for stretching.

	// SRAM port wiring.
	logic [7:0] sram_rdata;
	wire busy = (state_reg != ST_IDLE);
	// Host writes land only while idle; during execution they are dropped.
	// RL11 ignore host data
	wire host_we = HOST_WE_IN && !busy;
	wire store_we = (state_reg == ST_STORE);
	wire sram_we = store_we || host_we;
	wire [ADDR_W-1:0] sram_waddr = store_we ? addr_reg : HOST_ADDR_IN;
	wire [7:0] sram_wdata = store_we ? shift_reg : HOST_DATA_IN;
	// The registered read port looks one byte ahead of the pointer, so the opcode, length and fetch states find the byte at the
	// pointer already waiting in the read register; while idle it looks at the start address for the opcode.
	wire [ADDR_W-1:0] sram_raddr = busy ? addr_reg + 9'h001 : START_ADDR_IN;

	seq_sram u_sram (
		.clk(CLK_IN),
		.we(sram_we),
		.waddr(sram_waddr),
		.wdata(sram_wdata),
		.raddr(sram_raddr),
		.rdata(sram_rdata)
	);

	// Command decode.
	wire is_write = (op_reg == OP_WRITE_DATA);
	wire is_read = (op_reg == OP_READ_ACK) || (op_reg == OP_READ_NACK);
	wire op_ok = (sram_rdata == OP_WRITE_DATA) || (sram_rdata == OP_READ_ACK) || (sram_rdata == OP_READ_NACK);
	// Quarter tick. SCL is released at the end of quarter 1, so a slave still holding it low in quarter 2
	// stretches the clock; quarter 1 is driven low by us and must never count as a stretch.
	wire stretch = (phase_reg == 2'h2) && !scl_s2_reg;
	wire qtr_full = (qtr_reg == QUARTER_LAST);
	wire tick = qtr_full && !stretch;
	// The divider parks at its last count while stretched, so the quarter resumes without a long wrap.
	wire [QTR_W-1:0] qtr_step = qtr_full ? qtr_reg : qtr_reg + 10'h001;
	wire bit_end = tick && (phase_reg == 2'h3);
	wire last_byte = (cnt_reg == 9'h001);
	// Master pulls SDA low for a 0 bit or an ACK.
	// RL8 NACK final byte
	wire ack_drive = !((op_reg == OP_READ_NACK) && last_byte);
	// RL13 MSB first out
	wire sda_want_lo = (bit_reg == LAST_BIT) ? (is_read && ack_drive) : (is_write && !shift_reg[7]);

	// Two-flop synchronisers for pin inputs.
	always_ff @(posedge CLK_IN) begin
		sda_s1_reg <= SDA_IN;
		sda_s2_reg <= sda_s1_reg;
		scl_s1_reg <= SCL_IN;
		scl_s2_reg <= scl_s1_reg;
	end

	// Next-state logic for packet walking.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: if (RUN_IN) state_next = ST_OPC;
			// The opcode was read from the start address on the run edge.
			ST_OPC: state_next = op_ok ? ST_LEN : ST_END;
			ST_LEN: state_next = ST_FETCH;
			ST_FETCH: state_next = ST_BYTE;
			ST_BYTE: if (bit_end && (bit_reg == LAST_BIT)) state_next = is_read ? ST_STORE : (last_byte ? ST_END : ST_FETCH);
			ST_STORE: state_next = last_byte ? ST_END : ST_FETCH;
			ST_END: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	// State register and status flags.
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			state_reg <= ST_IDLE;
			done_reg <= 1'b0;
			ign_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			done_reg <= (state_reg == ST_END);
			ign_reg <= HOST_WE_IN && busy;
		end
	end

	// Packet pointer, opcode and count handling.
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			addr_reg <= '0;
			op_reg <= 8'h00;
			cnt_reg <= '0;
			next_addr_reg <= '0;
			bad_reg <= 1'b0;
			nack_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_IDLE: if (RUN_IN) begin
					addr_reg <= START_ADDR_IN;
					nack_reg <= 1'b0;
					bad_reg <= 1'b0;
				end
				ST_OPC: begin
					op_reg <= sram_rdata;
					bad_reg <= !op_ok;
					addr_reg <= addr_reg + 9'h001;
				end
				ST_LEN: begin
					// RL2 write zero 256
					// RL5 read zero 256
					// RL9 nack-read zero 256
					cnt_reg <= len_of(sram_rdata);
					addr_reg <= addr_reg + 9'h001;
				end
				ST_BYTE: if (bit_end && (bit_reg == LAST_BIT) && is_write) begin
					// RL1 step write data
					cnt_reg <= cnt_reg - 9'h001;
					addr_reg <= addr_reg + 9'h001;
					// RL13 sample slave ACK
					if (sda_s2_reg) nack_reg <= 1'b1;
				end
				ST_STORE: begin
					// RL4 step read bytes
					cnt_reg <= cnt_reg - 9'h001;
					addr_reg <= addr_reg + 9'h001;
				end
				ST_END: next_addr_reg <= addr_reg;
				default: ;
			endcase
		end
	end

	// Bit engine: quarter-period timing, shifting and pin drive.
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			qtr_reg <= '0;
			phase_reg <= 2'h0;
			bit_reg <= 4'h0;
			shift_reg <= READ_FILL;
			scl_lo_reg <= 1'b0;
			sda_lo_reg <= 1'b0;
		end else if (state_reg == ST_FETCH) begin
			// Load the write byte, or the FFh filler for reads.
			shift_reg <= is_write ? sram_rdata : READ_FILL;
			qtr_reg <= '0;
			phase_reg <= 2'h0;
			bit_reg <= 4'h0;
			scl_lo_reg <= 1'b1;
		end else if (state_reg == ST_BYTE) begin
			qtr_reg <= tick ? '0 : qtr_step;
			if (tick) begin
				phase_reg <= phase_reg + 2'h1;
				case (phase_reg)
					// SDA changes only while SCL is low.
					2'h0: sda_lo_reg <= sda_want_lo;
					2'h1: scl_lo_reg <= 1'b0;
					2'h2: if (is_read && (bit_reg != LAST_BIT)) begin
						// RL7 capture received bit
						shift_reg <= {shift_reg[6:0], sda_s2_reg};
					end else if (is_write && (bit_reg != LAST_BIT)) begin
						shift_reg <= {shift_reg[6:0], 1'b1};
					end
					default: begin
						scl_lo_reg <= 1'b1;
						bit_reg <= (bit_reg == LAST_BIT) ? 4'h0 : bit_reg + 4'h1;
					end
				endcase
			end
		end else if (state_reg == ST_END) begin
			// Leave SCL low, SDA released; a following Stop takes over.
			sda_lo_reg <= 1'b0;
		end else if (state_reg == ST_IDLE) begin
			scl_lo_reg <= scl_lo_reg;
		end
	end

	// Registered outputs.
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			BUSY_OUT <= 1'b0;
			SCL_OE_N_OUT <= 1'b1;
			SDA_OE_N_OUT <= 1'b1;
		end else begin
			BUSY_OUT <= busy;
			SCL_OE_N_OUT <= !scl_lo_reg;
			SDA_OE_N_OUT <= !sda_lo_reg;
		end
	end
	assign DONE_OUT = done_reg;
	assign NEXT_ADDR_OUT = next_addr_reg;
	assign NACK_SEEN_OUT = nack_reg;
	assign BAD_OP_OUT = bad_reg;
	assign HOST_IGNORED_OUT = ign_reg;
	assign SCL_OUT = 1'b0;
	assign SDA_OUT = 1'b0;
endmodule

// ### bench/i2c_data_cmds_sva.sv
// Port checker for the I2C data command executor.
`timescale 1ns/1ps
module i2c_data_cmds_sva
	import i2c_seq_pkg::*;
(
	// Watched ports.
	input wire logic CLK_IN,
	input wire logic RESET_IN,
	input wire logic RUN_IN,
	input wire logic BUSY_OUT,
	input wire logic DONE_OUT,
	input wire logic BAD_OP_OUT,
	input wire logic HOST_WE_IN,
	input wire logic HOST_IGNORED_OUT,
	input wire logic SCL_OUT,
	input wire logic SCL_OE_N_OUT,
	input wire logic SDA_OUT,
	input wire logic SDA_OE_N_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RESET_IN);
	// A low SCL phase lasts two quarters, far more than eight cycles.
	sequence scl_low_hold;
		!SCL_OE_N_OUT [*8];
	endsequence
	chk_done_pulse: assert property (DONE_OUT |=> !DONE_OUT) else $error("done too long");
	chk_run_busy: assert property (RUN_IN && !BUSY_OUT && !DONE_OUT && !$past(DONE_OUT) |-> ##[1:2] BUSY_OUT)
		else $error("run not taken");
	chk_done_busy: assert property (DONE_OUT |-> $past(BUSY_OUT)) else $error("done without run");
	chk_done_idle: assert property (DONE_OUT |-> ##[0:2] !BUSY_OUT) else $error("busy after done");
	chk_bad_ends: assert property ($rose(BAD_OP_OUT) |-> ##[0:3] !BUSY_OUT) else $error("bad op runs");
	chk_host_drop: assert property (HOST_WE_IN && BUSY_OUT && $past(BUSY_OUT)
		&& !DONE_OUT && !$past(DONE_OUT) |=> HOST_IGNORED_OUT) else $error("host write kept");
	chk_drop_busy: assert property (HOST_IGNORED_OUT |-> BUSY_OUT || DONE_OUT) else $error("drop while idle");
	chk_drop_cause: assert property (HOST_IGNORED_OUT |-> $past(HOST_WE_IN)) else $error("stray drop");
	chk_open_drain: assert property (!SCL_OUT && !SDA_OUT) else $error("pin driven high");
	chk_sda_scl_low: assert property ($changed(SDA_OE_N_OUT) |-> !$past(SCL_OE_N_OUT))
		else $error("sda moved with scl high");
	chk_scl_low: assert property ($fell(SCL_OE_N_OUT) |-> scl_low_hold) else $error("short scl low");
endmodule
bind i2c_data_cmds i2c_data_cmds_sva chk (.CLK_IN, .RESET_IN, .RUN_IN, .BUSY_OUT, .DONE_OUT, .BAD_OP_OUT,
	.HOST_WE_IN, .HOST_IGNORED_OUT, .SCL_OUT, .SCL_OE_N_OUT, .SDA_OUT, .SDA_OE_N_OUT);

// ### bench/i2c_slave_model.sv
// Behavioural I2C slave that logs every byte and acknowledge slot.
`timescale 1ns/1ps
module i2c_slave_model (
	input wire logic rst_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic rd_mode_in,
	input wire logic nack_in,
	output logic sda_pull_out,
	output int nbytes_out,
	output logic [7:0] log_out [0:15],
	output logic ack_out [0:15]
);
	int seen = 0; // Slots seen at rising SCL.
	int slot = 0; // Slot in force, moved only while SCL is low.
	logic [7:0] shift_reg;
	logic [7:0] tx_byte;
	initial nbytes_out = 0;
	assign tx_byte = 8'hA0 + nbytes_out[7:0];
	// read bytes: MSB first, released in the acknowledge slot.
	// write acknowledge: pulled low unless told to refuse.
	assign sda_pull_out = rd_mode_in ? (slot < 8 && !tx_byte[7 - slot]) : (slot == 8 && !nack_in);
	// framing done upstream
	// Start, address and repeated Start come from other commands, so slots count from the first SCL fall.
	// Sampling on rising SCL, as the master only moves SDA while SCL is low.
	always @(posedge scl_in or posedge rst_in) begin
		if (rst_in) seen = 0;
		else begin
			if (seen < 8) shift_reg = {shift_reg[6:0], sda_in};
			else begin
				log_out[nbytes_out[3:0]] = shift_reg;
				ack_out[nbytes_out[3:0]] = sda_in;
				nbytes_out = nbytes_out + 1;
			end
			seen = (seen + 1) % 9;
		end
	end
	always @(negedge scl_in or posedge rst_in) slot = rst_in ? 0 : seen;
endmodule

// ### bench/i2c_data_cmds_tb.sv
// Self-checking bench for the I2C data command executor.
`timescale 1ns/1ps
module i2c_data_cmds_tb;
	import i2c_seq_pkg::*;
	logic CLK_IN = 1'b0;
	logic RESET_IN = 1'b1;
	logic RUN_IN = 1'b0;
	logic [ADDR_W-1:0] START_ADDR_IN = 9'h000;
	logic HOST_WE_IN = 1'b0;
	logic [ADDR_W-1:0] HOST_ADDR_IN = 9'h000;
	logic [7:0] HOST_DATA_IN = 8'h00;
	logic rd_mode = 1'b0;
	logic nack_wr = 1'b0;
	wire logic busy, done, nack_seen, bad_op, ignored, scl_o, scl_oe_n, sda_o, sda_oe_n, sda_pull;
	wire logic [ADDR_W-1:0] next_addr;
	// Both lines have pull-ups, so a released line reads high.
	// supply kept on
	// The strong pull-up supply is taken as always on, so only the reset in zero_write_case or a wait timeout cuts a run short.
	wire logic scl = scl_oe_n;
	wire logic sda = sda_oe_n & !sda_pull;
	int nbytes;
	logic [7:0] log_b [0:15];
	logic ack_b [0:15];
	int mismatches = 0;
	int cmp_count = 0;
	int base;
	int rd_base;
	always #4 CLK_IN = ~CLK_IN;
	i2c_data_cmds uut (.CLK_IN, .RESET_IN, .RUN_IN, .START_ADDR_IN, .BUSY_OUT(busy), .DONE_OUT(done),
		.NEXT_ADDR_OUT(next_addr), .NACK_SEEN_OUT(nack_seen), .BAD_OP_OUT(bad_op), .HOST_WE_IN, .HOST_ADDR_IN,
		.HOST_DATA_IN, .HOST_IGNORED_OUT(ignored), .SCL_IN(scl), .SCL_OUT(scl_o), .SCL_OE_N_OUT(scl_oe_n),
		.SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE_N_OUT(sda_oe_n));
	i2c_slave_model slave (.rst_in(RESET_IN), .scl_in(scl), .sda_in(sda), .rd_mode_in(rd_mode),
		.nack_in(nack_wr), .sda_pull_out(sda_pull), .nbytes_out(nbytes), .log_out(log_b), .ack_out(ack_b));
	task automatic complete_run();
		if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [8:0] got, input logic [8:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Inputs move one nanosecond after the rising edge.
	task automatic tick();
		@(posedge CLK_IN);
		#1;
	endtask
	task automatic load(input logic [8:0] a, input logic [7:0] d);
		HOST_WE_IN = 1'b1;
		HOST_ADDR_IN = a;
		HOST_DATA_IN = d;
		tick();
	endtask
	task automatic run(input logic [8:0] a);
		HOST_WE_IN = 1'b0;
		RUN_IN = 1'b1;
		START_ADDR_IN = a;
		tick();
		RUN_IN = 1'b0;
	endtask
	// Bounded waits; running out ends the run as a failure.
	task automatic wait_for(input int bytes);
		int i;
		for (i = 0; i < 40000 && (bytes > 0 ? nbytes < bytes : done !== 1'b1); i++) tick();
		if (i == 40000) begin
			mismatches++;
			complete_run();
		end
	endtask
	task automatic bad_op_case();
		load(9'h000, 8'h55);
		run(9'h000);
		wait_for(0);
		check(9'(bad_op), 9'h001);
	endtask
	task automatic read_case(input logic [8:0] a, input logic [7:0] op, input logic last_ack);
		base = nbytes;
		rd_mode = 1'b1;
		load(a, op);
		load(a + 9'h001, 8'h02);
		load(a + 9'h002, READ_FILL);
		load(a + 9'h003, READ_FILL);
		run(a);
		wait_for(0);
		check(next_addr, a + 9'h004);
		check(9'(log_b[base]), 9'(8'hA0 + base));
		check(9'(log_b[base + 1]), 9'(8'hA1 + base));
		check(9'(ack_b[base]), 9'h000);
		check(9'(ack_b[base + 1]), 9'(last_ack));
	endtask
	task automatic echo_case();
		base = nbytes;
		rd_mode = 1'b0;
		nack_wr = 1'b1;
		load(9'h00C, OP_WRITE_DATA);
		run(9'h00C);
		repeat (4) tick();
		load(9'h00E, 8'h00);
		HOST_WE_IN = 1'b0;
		check(9'(ignored), 9'h001);
		wait_for(0);
		check(next_addr, 9'h010);
		check(9'(log_b[base]), 9'(8'hA0 + rd_base));
		check(9'(log_b[base + 1]), 9'(8'hA1 + rd_base));
		check(9'(nack_seen), 9'h001);
	endtask
	task automatic zero_write_case();
		base = nbytes;
		// The slave must listen, not drive its own read bytes, during this write.
		rd_mode = 1'b0;
		nack_wr = 1'b0;
		load(9'h028, OP_WRITE_DATA);
		load(9'h029, 8'h00);
		load(9'h02A, 8'h3C);
		load(9'h02B, 8'hC3);
		run(9'h028);
		wait_for(base + 2);
		check(9'(busy), 9'h001);
		check(9'(log_b[base]), 9'h03C);
		check(9'(log_b[base + 1]), 9'h0C3);
		check(9'(nack_seen), 9'h000);
		RESET_IN = 1'b1;
		repeat (2) tick();
		RESET_IN = 1'b0;
		tick();
		check(9'(busy), 9'h000);
	endtask
	initial begin
		repeat (6) @(posedge CLK_IN);
		#1;
		RESET_IN = 1'b0;
		bad_op_case();
		rd_base = nbytes;
		read_case(9'h00C, OP_READ_ACK, 1'b0);
		echo_case();
		read_case(9'h020, OP_READ_NACK, 1'b1);
		zero_write_case();
		complete_run();
	end
endmodule
